// ---- hdl/sst_map.vh ----
// Behaviour
// - Two self-test modes: unpowered and powered
// - Command register value selects and starts mode
// - Unpowered: inline, bypass, sequential, all gates, done
// - Run relay on/off once, confirm sampled
// - Inline confirm late past time: inline fault
// - No inline confirm input: inline passes unchecked
// - Inline time Off skips inline test
// - Bypass and up-to-speed relays on/off, confirm checked
// - Bypass confirm late past time: bypass fault
// - Fan relay, no confirm input: bypass passes
// - Fire gates alone in order 6,3,5,2,4,1
// - Show number of gate now firing
// - Fire all six gates together
// - Enter key skips to next test
// - Unpowered: voltage or current aborts, abnormal fault
// - Powered: shorted pole, open pole, done
// - Poles alone; current: thyristor or ground fault
// - Current on wrong phase: transformer fault
// - Expected phase without current: thyristor fault
// - Powered: line voltage loss gives abnormal fault
// - Measured phase order mismatch: phase-order fault
`ifndef SST_MAP_VH
`define SST_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SST_OFF_CMD 6'h00
`define SST_OFF_CFG 6'h01
`define SST_OFF_INL 6'h02
`define SST_OFF_BYP 6'h03
`define SST_OFF_DWELL 6'h04
`define SST_OFF_STAT 6'h05

// ----------------------------------------
// Command values
// ----------------------------------------
`define SST_CMD_STD 8'h01
`define SST_CMD_PWR 8'h02

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define SST_CFG_INL_ASG 0
`define SST_CFG_BYP_ASG 1
`define SST_CFG_BYP_FAN 2
`define SST_CFG_BYP_DED 3
`define SST_CFG_ORDER 4
`define SST_CFG_RST 5'h08

// ----------------------------------------
// Times, in milliseconds; tick and clock periods in nanoseconds
// ----------------------------------------
`define SST_INL_RST 16'h01f4
`define SST_BYP_RST 16'h01f4
`define SST_DWELL_RST 16'h03e8
`define SST_SETTLE_MS 16'h0002
`define SST_TICK_NS 1000000
`define SST_CLK_NS 8
`define SST_TICK_CYC (`SST_TICK_NS / `SST_CLK_NS)

// ----------------------------------------
// Status fields
// ----------------------------------------
`define SST_ST_STATE 0
`define SST_ST_GATE 4
`define SST_ST_DONE 8
`define SST_ST_BUSY 9
`define SST_ST_FLT 16

// ----------------------------------------
// Fault bits
// ----------------------------------------
`define SST_F_INL 0
`define SST_F_BYP 1
`define SST_F_ABN 2
`define SST_F_THY 3
`define SST_F_GND 4
`define SST_F_CT 5
`define SST_F_ORD 6

`endif

// ---- hdl/sst_seq.v ----
`timescale 1ns/100ps
`default_nettype none
`include "sst_map.vh"

module sst_seq #(
    parameter [19:0] TICK_CYC = `SST_TICK_CYC
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire key_enter,
    input wire inline_confirm,
    input wire bypass_confirm,
    input wire line_volt_det,
    input wire phase_cur_det,
    input wire ground_cur_det,
    input wire [2:0] pole_cur_det,
    input wire phase_order_meas,
    output reg run_relay_q,
    output reg uts_relay_q,
    output reg bypass_relay_q,
    output reg [5:0] gate_q,
    output reg [2:0] pole_en_q,
    output reg loop_en_q
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_IN_ON = 4'h1;
    localparam [3:0] S_IN_OFF = 4'h2;
    localparam [3:0] S_BY_ON = 4'h3;
    localparam [3:0] S_BY_OFF = 4'h4;
    localparam [3:0] S_G_SEQ = 4'h5;
    localparam [3:0] S_G_ALL = 4'h6;
    localparam [3:0] S_SHORT = 4'h7;
    localparam [3:0] S_OPEN = 4'h8;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Test that follows when the current one is skipped
    function [3:0] skip_to;
        input [3:0] s;
        begin
            case (s)
                S_IN_ON, S_IN_OFF: skip_to = S_BY_ON;
                S_BY_ON, S_BY_OFF: skip_to = S_G_SEQ;
                S_G_SEQ: skip_to = S_G_ALL;
                S_SHORT: skip_to = S_OPEN;
                default: skip_to = S_IDLE;
            endcase
        end
    endfunction

    // Firing order 6,3,5,2,4,1 as gate numbers
    function [2:0] gate_num;
        input [2:0] i;
        begin
            case (i)
                3'd0: gate_num = 3'd6;
                3'd1: gate_num = 3'd3;
                3'd2: gate_num = 3'd5;
                3'd3: gate_num = 3'd2;
                3'd4: gate_num = 3'd4;
                default: gate_num = 3'd1;
            endcase
        end
    endfunction

    function [5:0] gate_bit;
        input [2:0] i;
        begin
            gate_bit = 6'h01 << (gate_num(i) - 3'd1);
        end
    endfunction

    function [2:0] pole_bit;
        input [2:0] i;
        begin
            pole_bit = 3'h1 << i[1:0];
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [9:0] pin_raw;
    reg [9:0] s1_q;
    reg [9:0] s2_q;
    reg [9:0] s3_q;
    reg [9:0] pin_q;
    reg key_prev_q;

    assign pin_raw = {key_enter, inline_confirm, bypass_confirm,
                      line_volt_det, phase_cur_det, ground_cur_det,
                      pole_cur_det, phase_order_meas};

    // A change counts once the second and third stages agree
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 10'h000;
            s2_q <= 10'h000;
            s3_q <= 10'h000;
            pin_q <= 10'h000;
            key_prev_q <= 1'b0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
            key_prev_q <= pin_q[9];
        end
    end

    wire key_press = pin_q[9] & ~key_prev_q;
    wire inl_f = pin_q[8];
    wire byp_f = pin_q[7];
    wire volt_f = pin_q[6];
    wire cur_f = pin_q[5];
    wire gnd_f = pin_q[4];
    wire [2:0] pcur_f = pin_q[3:1];
    wire ord_f = pin_q[0];

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    reg [19:0] div_q;
    reg tick_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 20'h00000;
            tick_q <= 1'b0;
        end else if (div_q >= TICK_CYC - 20'h00001) begin
            div_q <= 20'h00000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 20'h00001;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    reg [4:0] cfg_q;
    reg [15:0] inl_time_q;
    reg [15:0] byp_time_q;
    reg [15:0] dwell_q;
    reg wr_pend_q;
    reg [5:0] wa_q;
    reg go_std_q;
    reg go_pwr_q;
    reg [3:0] st_q;
    reg [2:0] idx_q;
    reg [6:0] flt_q;
    reg done_q;
    reg [31:0] rd_d;

    wire addr_ph = hsel & hready & htrans[1];

    always @* begin
        rd_d = 32'h00000000;
        case (haddr[7:2])
            `SST_OFF_CFG: rd_d = {27'h0000000, cfg_q};
            `SST_OFF_INL: rd_d = {16'h0000, inl_time_q};
            `SST_OFF_BYP: rd_d = {16'h0000, byp_time_q};
            `SST_OFF_DWELL: rd_d = {16'h0000, dwell_q};
            `SST_OFF_STAT: begin
                rd_d[`SST_ST_STATE +: 4] = st_q;
                // Shows the gate being fired during the sequence
                if (st_q == S_G_SEQ) begin
                    rd_d[`SST_ST_GATE +: 3] = gate_num(idx_q);
                end
                rd_d[`SST_ST_DONE] = done_q;
                rd_d[`SST_ST_BUSY] = (st_q != S_IDLE);
                rd_d[`SST_ST_FLT +: 7] = flt_q;
            end
            default: rd_d = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            wr_pend_q <= 1'b0;
            wa_q <= 6'h00;
            cfg_q <= `SST_CFG_RST;
            inl_time_q <= `SST_INL_RST;
            byp_time_q <= `SST_BYP_RST;
            dwell_q <= `SST_DWELL_RST;
            go_std_q <= 1'b0;
            go_pwr_q <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            go_std_q <= 1'b0;
            go_pwr_q <= 1'b0;
            wr_pend_q <= addr_ph & hwrite;
            if (addr_ph) begin
                wa_q <= haddr[7:2];
                hrdata <= hwrite ? 32'h00000000 : rd_d;
            end
            if (wr_pend_q) begin
                case (wa_q)
                    `SST_OFF_CMD: begin
                        // Only entry into self test
                        go_std_q <= (hwdata[7:0] == `SST_CMD_STD);
                        go_pwr_q <= (hwdata[7:0] == `SST_CMD_PWR);
                    end
                    `SST_OFF_CFG: cfg_q <= hwdata[4:0];
                    `SST_OFF_INL: inl_time_q <= hwdata[15:0];
                    `SST_OFF_BYP: byp_time_q <= hwdata[15:0];
                    `SST_OFF_DWELL: dwell_q <= hwdata[15:0];
                    default: wa_q <= wa_q;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Sequencer decisions
    // ----------------------------------------
    reg [15:0] tmr_q;
    reg [3:0] nxt_d;
    reg [2:0] idx_d;
    reg [6:0] flt_d;

    wire t_dwell = (tmr_q >= dwell_q);
    wire t_inl = (tmr_q >= inl_time_q);
    wire t_byp = (tmr_q >= byp_time_q);
    wire inl_chk = cfg_q[`SST_CFG_INL_ASG];
    wire byp_fan = cfg_q[`SST_CFG_BYP_FAN];
    wire byp_chk = ~(byp_fan & ~cfg_q[`SST_CFG_BYP_ASG]);
    wire ord_bad = (ord_f != cfg_q[`SST_CFG_ORDER]);
    wire std_run = (st_q >= S_IN_ON) && (st_q <= S_G_ALL);
    wire pwr_run = (st_q == S_SHORT) || (st_q == S_OPEN);
    wire [2:0] exp_pole = pole_bit(idx_q);

    always @* begin
        nxt_d = st_q;
        idx_d = idx_q;
        flt_d = 7'h00;
        case (st_q)
            S_IDLE: begin
                if (go_std_q) begin
                    // Time Off skips the inline test outright
                    nxt_d = (inl_time_q == 16'h0000) ? S_BY_ON : S_IN_ON;
                    idx_d = 3'd0;
                end else if (go_pwr_q) begin
                    nxt_d = S_SHORT;
                    idx_d = 3'd0;
                end
            end
            S_IN_ON: begin
                if (!inl_chk) begin
                    if (t_dwell) nxt_d = S_IN_OFF;
                end else if (inl_f) begin
                    nxt_d = S_IN_OFF;
                end else if (t_inl) begin
                    flt_d[`SST_F_INL] = 1'b1;
                end
            end
            S_IN_OFF: begin
                if (!inl_chk) begin
                    if (t_dwell) nxt_d = S_BY_ON;
                end else if (!inl_f) begin
                    nxt_d = S_BY_ON;
                end else if (t_inl) begin
                    flt_d[`SST_F_INL] = 1'b1;
                end
            end
            S_BY_ON: begin
                if (!byp_chk) begin
                    if (t_dwell) nxt_d = S_BY_OFF;
                end else if (byp_f) begin
                    nxt_d = S_BY_OFF;
                end else if (t_byp) begin
                    flt_d[`SST_F_BYP] = 1'b1;
                end
            end
            S_BY_OFF: begin
                if (!byp_chk) begin
                    if (t_dwell) nxt_d = S_G_SEQ;
                end else if (!byp_f) begin
                    nxt_d = S_G_SEQ;
                end else if (t_byp) begin
                    flt_d[`SST_F_BYP] = 1'b1;
                end
                idx_d = 3'd0;
            end
            S_G_SEQ: begin
                if (t_dwell) begin
                    if (idx_q == 3'd5) begin
                        nxt_d = S_G_ALL;
                        idx_d = 3'd0;
                    end else begin
                        idx_d = idx_q + 3'd1;
                    end
                end
            end
            S_G_ALL: begin
                if (t_dwell) nxt_d = S_IDLE;
            end
            S_SHORT: begin
                // Any current with a single pole energised is a fault
                if (pcur_f != 3'h0) begin
                    if (gnd_f) flt_d[`SST_F_GND] = 1'b1;
                    else flt_d[`SST_F_THY] = 1'b1;
                end else if (t_dwell) begin
                    if (idx_q == 3'd2) begin
                        nxt_d = S_OPEN;
                        idx_d = 3'd0;
                    end else begin
                        idx_d = idx_q + 3'd1;
                    end
                end
            end
            S_OPEN: begin
                // Current of the previous pole needs time to die away
                if (tmr_q >= `SST_SETTLE_MS && (pcur_f & ~exp_pole) != 3'h0) begin
                    flt_d[`SST_F_CT] = 1'b1;
                end else if (t_dwell) begin
                    if ((pcur_f & exp_pole) == 3'h0) begin
                        flt_d[`SST_F_THY] = 1'b1;
                    end else if (idx_q == 3'd2) begin
                        nxt_d = S_IDLE;
                    end else begin
                        idx_d = idx_q + 3'd1;
                    end
                end
            end
            default: nxt_d = S_IDLE;
        endcase
        // Enter moves straight on to the following test
        if (key_press && st_q != S_IDLE && flt_d == 7'h00) begin
            nxt_d = skip_to(st_q);
            idx_d = 3'd0;
            if (nxt_d == S_BY_ON && st_q == S_IDLE) nxt_d = S_BY_ON;
        end
        if (std_run && (volt_f || cur_f)) begin
            flt_d[`SST_F_ABN] = 1'b1;
        end
        if ((pwr_run || go_pwr_q && st_q == S_IDLE) && !volt_f) begin
            flt_d[`SST_F_ABN] = 1'b1;
        end
        if ((pwr_run || go_pwr_q && st_q == S_IDLE) && ord_bad) begin
            flt_d[`SST_F_ORD] = 1'b1;
        end
    end

    // ----------------------------------------
    // Sequencer state and outputs
    // ----------------------------------------
    wire moving = (nxt_d != st_q) || (idx_d != idx_q);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
            idx_q <= 3'd0;
            tmr_q <= 16'h0000;
            flt_q <= 7'h00;
            done_q <= 1'b0;
            run_relay_q <= 1'b0;
            uts_relay_q <= 1'b0;
            bypass_relay_q <= 1'b0;
            gate_q <= 6'h00;
            pole_en_q <= 3'h0;
            loop_en_q <= 1'b0;
        end else if (flt_d != 7'h00) begin
            // Leave at once with every drive released
            st_q <= S_IDLE;
            idx_q <= 3'd0;
            tmr_q <= 16'h0000;
            flt_q <= flt_d;
            done_q <= 1'b0;
            run_relay_q <= 1'b0;
            uts_relay_q <= 1'b0;
            bypass_relay_q <= 1'b0;
            gate_q <= 6'h00;
            pole_en_q <= 3'h0;
            loop_en_q <= 1'b0;
        end else begin
            st_q <= nxt_d;
            idx_q <= idx_d;
            if (moving) begin
                tmr_q <= 16'h0000;
            end else if (tick_q && tmr_q != 16'hffff) begin
                tmr_q <= tmr_q + 16'h0001;
            end
            if (st_q == S_IDLE && nxt_d != S_IDLE) begin
                flt_q <= 7'h00;
                done_q <= 1'b0;
            end else if (st_q != S_IDLE && nxt_d == S_IDLE) begin
                done_q <= 1'b1;
            end
            run_relay_q <= (nxt_d == S_IN_ON);
            uts_relay_q <= (nxt_d == S_BY_ON);
            bypass_relay_q <= (nxt_d == S_BY_ON) &&
                cfg_q[`SST_CFG_BYP_DED] && !byp_fan;
            if (nxt_d == S_G_SEQ) begin
                gate_q <= gate_bit(idx_d);
            end else if (nxt_d == S_G_ALL) begin
                gate_q <= 6'h3f;
            end else begin
                gate_q <= 6'h00;
            end
            if (nxt_d == S_SHORT || nxt_d == S_OPEN) begin
                pole_en_q <= pole_bit(idx_d);
            end else begin
                pole_en_q <= 3'h0;
            end
            loop_en_q <= (nxt_d == S_OPEN);
        end
    end

endmodule
`default_nettype wire

// ---- test/sst_seq_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module sst_seq_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic line_volt_det,
    input wire logic run_relay_q,
    input wire logic uts_relay_q,
    input wire logic [5:0] gate_q,
    input wire logic [2:0] pole_en_q,
    input wire logic loop_en_q
);
    // ----------------------------------------
    // Output sequencing checks
    // ----------------------------------------
    default clocking mclk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    function automatic logic [5:0] next_gate(input logic [5:0] g);
        case (g)
            6'h20: next_gate = 6'h04;
            6'h04: next_gate = 6'h10;
            6'h10: next_gate = 6'h02;
            6'h02: next_gate = 6'h08;
            6'h08: next_gate = 6'h01;
            default: next_gate = 6'h3f;
        endcase
    endfunction
    a_gate_shape: assert property (
        gate_q == 6'h00 || $onehot(gate_q) || gate_q == 6'h3f)
        else $error("gate drive neither single nor all");
    a_gate_order: assert property (
        $onehot($past(gate_q)) && gate_q != $past(gate_q) && gate_q != 6'h00
        |-> gate_q == next_gate($past(gate_q)) || gate_q == 6'h3f)
        else $error("gate firing order wrong");
    a_gate_alone: assert property (
        gate_q != 6'h00 |-> !run_relay_q && !uts_relay_q && pole_en_q == 3'h0)
        else $error("gates fire beside relays or poles");
    a_relay_excl: assert property (
        run_relay_q |-> !uts_relay_q)
        else $error("run and up-to-speed relays on together");
    a_pole_single: assert property (
        $onehot0(pole_en_q))
        else $error("more than one pole energised");
    a_loop_pole: assert property (
        loop_en_q |-> $onehot(pole_en_q))
        else $error("loop current without a single pole");
    a_line_abort: assert property (
        line_volt_det [*8] |=> gate_q == 6'h00)
        else $error("gates still firing with line voltage");
    a_line_loss: assert property (
        !line_volt_det [*8] |=> pole_en_q == 3'h0)
        else $error("pole energised without line voltage");
    a_bus_ready: assert property (
        $past(hresetn) |-> hreadyout && !hresp)
        else $error("bus wait state or error response");
endmodule
bind sst_seq sst_seq_monitor i_mon (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .line_volt_det(line_volt_det),
    .run_relay_q(run_relay_q), .uts_relay_q(uts_relay_q), .gate_q(gate_q),
    .pole_en_q(pole_en_q), .loop_en_q(loop_en_q));
`default_nettype wire

// ---- test/sst_plant.sv ----
`timescale 1ns/100ps
`default_nettype none
module sst_plant (
    input wire logic hclk,
    input wire logic [1:0] pmode,
    input wire logic run_relay_q,
    input wire logic uts_relay_q,
    input wire logic bypass_relay_q,
    input wire logic [2:0] pole_en_q,
    input wire logic loop_en_q,
    output logic inline_confirm,
    output logic bypass_confirm,
    output logic ground_cur_det,
    output logic [2:0] pole_cur_det
);
    // ----------------------------------------
    // Contactors, poles; mode 1 stuck, 2 wrong CT, 3 short to ground
    // ----------------------------------------
    logic [2:0] run_d = 3'h0;
    logic [2:0] uts_d = 3'h0;
    always @(posedge hclk) begin
        run_d <= {run_d[1:0], run_relay_q};
        uts_d <= {uts_d[1:0], uts_relay_q | bypass_relay_q};
    end
    always_comb begin
        inline_confirm = (pmode != 2'h1) && run_d[2];
        bypass_confirm = (pmode != 2'h1) && uts_d[2];
        ground_cur_det = (pmode == 2'h3) && (pole_en_q != 3'h0);
        case (pmode)
            2'h1: pole_cur_det = 3'h0;
            2'h2: pole_cur_det = loop_en_q ? {pole_en_q[1:0], pole_en_q[2]} : 3'h0;
            2'h3: pole_cur_det = pole_en_q;
            default: pole_cur_det = loop_en_q ? pole_en_q : 3'h0;
        endcase
    end
endmodule
`default_nettype wire

// ---- test/sst_seq_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module sst_seq_tb;
    logic hclk, hresetn, hsel, hwrite, key_enter, line_volt_det, phase_order_meas, phase_cur_det;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, pmode;
    logic hreadyout, hresp, inline_confirm, bypass_confirm, ground_cur_det;
    logic run_relay_q, uts_relay_q, bypass_relay_q, loop_en_q, rseen, bseen;
    logic [2:0] pole_cur_det, pole_en_q, pseen;
    logic [5:0] gate_q;
    logic [5:0] gq[$];
    logic [5:0] gexp[7] = '{6'h20, 6'h04, 6'h10, 6'h02, 6'h08, 6'h01, 6'h3f};
    int num_errors = 0;
    int total_checks = 0;

    sst_seq #(.TICK_CYC(20'd10)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .key_enter(key_enter), .inline_confirm(inline_confirm),
        .bypass_confirm(bypass_confirm), .line_volt_det(line_volt_det),
        .phase_cur_det(phase_cur_det), .ground_cur_det(ground_cur_det),
        .pole_cur_det(pole_cur_det), .phase_order_meas(phase_order_meas),
        .run_relay_q(run_relay_q), .uts_relay_q(uts_relay_q),
        .bypass_relay_q(bypass_relay_q), .gate_q(gate_q), .pole_en_q(pole_en_q),
        .loop_en_q(loop_en_q));
    sst_plant i_plant (.hclk(hclk), .pmode(pmode), .run_relay_q(run_relay_q),
        .uts_relay_q(uts_relay_q), .bypass_relay_q(bypass_relay_q),
        .pole_en_q(pole_en_q), .loop_en_q(loop_en_q), .inline_confirm(inline_confirm),
        .bypass_confirm(bypass_confirm), .ground_cur_det(ground_cur_det),
        .pole_cur_det(pole_cur_det));

    // ----------------------------------------
    // Clock, recorder, bus and check tasks
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (gate_q !== 6'h00 && gate_q !== (gq.size() > 0 ? gq[$] : 6'h00))
            gq.push_back(gate_q);
        rseen = rseen | run_relay_q;
        bseen = bseen | (uts_relay_q & bypass_relay_q);
        pseen = pseen | pole_en_q;
    end
    task automatic finish_test;
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk(n, r, e);
    endtask
    task automatic start(input logic [7:0] cmd, input logic [1:0] m);
        pmode <= m;
        repeat (8) @(posedge hclk);
        gq.delete();
        rseen = 1'b0;
        bseen = 1'b0;
        pseen = 3'h0;
        wr(8'h00, {24'h0, cmd});
    endtask
    task automatic finish(input logic [6:0] ef);
        logic [31:0] st;
        int n;
        n = 0;
        do begin
            xfer(8'h14, 1'b0, 32'h0, st);
            n++;
        end while (st[9] !== 1'b0 && n < 2000);
        if (n >= 2000)
            num_errors++;
        chk("fault bits", {25'h0, st[22:16]}, {25'h0, ef});
        chk("state", {28'h0, st[3:0]}, 32'h0);
        chk("outputs", {19'h0, run_relay_q, uts_relay_q, bypass_relay_q, gate_q, pole_en_q,
            loop_en_q}, 32'h0);
        if (ef == 7'h00)
            chk("done", {31'h0, st[8]}, 32'h1);
    endtask
    task automatic wait_gate(input logic [5:0] g);
        int n;
        n = 0;
        while (gate_q !== g && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 3000)
            num_errors++;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd("cfg", 8'h04, 32'h8);
        rd("inline time", 8'h08, 32'h1f4);
        rd("bypass time", 8'h0c, 32'h1f4);
        rd("dwell", 8'h10, 32'h3e8);
        rd("status", 8'h14, 32'h0);
        rd("cmd", 8'h00, 32'h0);
        wr(8'h18, 32'hffffffff);
        rd("unmapped", 8'h18, 32'h0);
        wr(8'h14, 32'hffffffff);
        rd("status ro", 8'h14, 32'h0);
        wr(8'h08, 32'h5);
        wr(8'h0c, 32'h5);
        wr(8'h10, 32'h2);
        wr(8'h04, 32'hb);
    endtask
    task automatic t_std_ok;
        start(8'h01, 2'h0);
        wait_gate(6'h20);
        rd("gate number", 8'h14, 32'h265);
        finish(7'h00);
        chk("gate count", gq.size(), 7);
        foreach (gexp[i])
            chk("gate", {26'h0, gq[i]}, {26'h0, gexp[i]});
        chk("run relay", {31'h0, rseen}, 32'h1);
        chk("bypass relays", {31'h0, bseen}, 32'h1);
    endtask
    task automatic t_std_faults;
        start(8'h01, 2'h1);
        finish(7'h01);
        start(8'h01, 2'h1);
        wait(run_relay_q === 1'b1);
        key_enter <= 1'b1;
        repeat (8) @(posedge hclk);
        key_enter <= 1'b0;
        finish(7'h02);
        wr(8'h04, 32'h4);
        start(8'h01, 2'h1);
        finish(7'h00);
        chk("fan relay", {31'h0, bseen}, 32'h0);
        wr(8'h04, 32'hb);
        start(8'h01, 2'h0);
        wait_gate(6'h04);
        line_volt_det <= 1'b1;
        finish(7'h04);
        line_volt_det <= 1'b0;
        start(8'h01, 2'h0);
        wait_gate(6'h20);
        phase_cur_det <= 1'b1;
        finish(7'h04);
        phase_cur_det <= 1'b0;
        wr(8'h08, 32'h0);
        start(8'h01, 2'h0);
        finish(7'h00);
        chk("run relay", {31'h0, rseen}, 32'h0);
        wr(8'h08, 32'h5);
    endtask
    task automatic t_pwr(input logic [1:0] m, input logic ord, input logic [6:0] ef);
        line_volt_det <= 1'b1;
        phase_order_meas <= ord;
        start(8'h02, m);
        finish(ef);
        if (ef == 7'h00)
            chk("poles", {29'h0, pseen}, 32'h7);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        key_enter = 1'b0;
        line_volt_det = 1'b0;
        phase_cur_det = 1'b0;
        phase_order_meas = 1'b0;
        bseen = 1'b0;
        pmode = 2'h0;
        rseen = 1'b0;
        pseen = 3'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_regs();
        t_std_ok();
        t_std_faults();
        t_pwr(2'h0, 1'b0, 7'h00);
        t_pwr(2'h2, 1'b0, 7'h20);
        t_pwr(2'h3, 1'b0, 7'h10);
        t_pwr(2'h1, 1'b0, 7'h08);
        t_pwr(2'h0, 1'b1, 7'h40);
        line_volt_det <= 1'b0;
        repeat (12) @(posedge hclk);
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge hclk);
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
